//--- bench/ift_irq_tone_tb_top.sv
// self-checking bench for the interrupt flag and tone decode block
`timescale 1ns/1ps
module ift_irq_tone_tb_top;
  import ift_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic [TIMER_N-1:0] timer_evt = '0;
  logic [ALARM_N-1:0] power_alarm_evt = '0;
  logic hook_state = 1'b0;
  logic ring_trip_evt = 1'b0;
  logic calib_running = 1'b0;
  logic indirect_busy = 1'b0;
  logic tone_valid = 1'b0;
  logic [3:0] tone_code = 4'h0;
  logic irq;
  int n_fail = 0;
  int checked = 0;
  int cycles = 0;
  logic [DATA_W-1:0] rdat;
  logic rerr;
  logic [ADDR_W-1:0] pend_addr [3] = '{ADDR_PEND_TIMERS, ADDR_PEND_ALARM_LOOP, ADDR_PEND_MISC};
  logic [ADDR_W-1:0] mask_addr [3] = '{ADDR_MASK_TIMERS, ADDR_MASK_ALARM_LOOP, ADDR_MASK_MISC};

  always #25 pclk = ~pclk;

  ift_irq_tone ift_irq_tone_inst (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_evt(timer_evt), .power_alarm_evt(power_alarm_evt),
    .hook_state(hook_state), .ring_trip_evt(ring_trip_evt), .calib_running(calib_running),
    .indirect_busy(indirect_busy), .tone_valid(tone_valid), .tone_code(tone_code), .irq(irq)
  );

  // ==========================================================================
  // verdict and comparison
  task automatic stop_test();
    if (n_fail == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask : chk

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      stop_test();
    end
  end

  // ==========================================================================
  // apb transfer; one idle edge before setup so strobes never change twice
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // pready, pslverr and prdata are taken at the rising edge that completes the access
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rerr = pslverr;
    rdat = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // ==========================================================================
  // event stimulus and expected pending image {misc, alarm/loop, timers}
  task automatic fire(input int k);
    @(posedge pclk);
    if (k < 8) timer_evt <= 8'h01 << k;
    else if (k < 14) power_alarm_evt <= 6'h01 << (k - 8);
    else if (k == 14) ring_trip_evt <= 1'b1;
    else if (k == 15) hook_state <= ~hook_state;
    else if (k == 16) calib_running <= 1'b1;
    else if (k == 17) indirect_busy <= 1'b1;
    else begin
      tone_valid <= 1'b1;
      tone_code <= 4'($urandom);
    end
    @(posedge pclk);
    timer_evt <= '0;
    power_alarm_evt <= '0;
    ring_trip_evt <= 1'b0;
    indirect_busy <= 1'b0;
    tone_valid <= 1'b0;
    if (k == 16) hook_state <= ~hook_state;
    repeat (2) @(posedge pclk);
    calib_running <= 1'b0;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
  endtask : fire

  function automatic logic [23:0] exp_pend(input int k);
    logic [23:0] e;
    e = '0;
    if (k < 8) e[k] = 1'b1;
    else if (k < 14) e[8 + ALARM_LSB + k - 8] = 1'b1;
    else if (k == 14) e[8 + RING_BIT] = 1'b1;
    else if (k == 15) e[8 + LOOP_BIT] = 1'b1;
    else if (k == 16) e = 24'h040200;
    else if (k == 17) e[16 + INDIRECT_BIT] = 1'b1;
    else e[16 + TONE_BIT] = 1'b1;
    return e;
  endfunction : exp_pend

  // ==========================================================================
  // main sequence
  initial begin
    logic [23:0] e;
    logic [23:0] mv;
    int k;
    int s;
    void'($urandom(32'ha899));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    for (int r = 0; r < 3; r++) begin
      apb(1'b0, pend_addr[r], '0);
      chk("pending at reset", '0, rdat);
      apb(1'b0, mask_addr[r], '0);
      chk("mask at reset", '0, rdat);
    end
    apb(1'b0, ADDR_TONE_KEY, '0);
    chk("key status at reset", '0, rdat);
    // unmapped address answers with an error and no data
    apb(1'b0, 8'h04, '0);
    chk("unmapped error", 32'h1, {31'h0, rerr});
    chk("unmapped data", '0, rdat);
    s = $urandom_range(18);
    for (int i = 0; i < 19; i++) begin
      k = (i * 7 + s) % 19;
      e = exp_pend(k);
      mv = 24'($urandom);
      for (int r = 0; r < 3; r++) begin
        apb(1'b1, mask_addr[r], {24'h0, mv[8*r +: 8]});
        apb(1'b0, mask_addr[r], '0);
        chk("mask", {24'h0, mv[8*r +: 8] & (r == 2 ? 8'h07 : 8'hff)}, rdat);
      end
      fire(k);
      chk("irq raised", {31'h0, |(e & mv & 24'h07ffff)}, {31'h0, irq});
      for (int r = 0; r < 3; r++) begin
        apb(1'b1, pend_addr[r], '0);
        apb(1'b0, pend_addr[r], '0);
        chk("pending", {24'h0, e[8*r +: 8]}, rdat);
        apb(1'b1, pend_addr[r], 32'hff);
        apb(1'b0, pend_addr[r], '0);
        chk("cleared", '0, rdat);
      end
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      chk("irq idle", '0, {31'h0, irq});
    end
    for (int c = 0; c < 16; c++) begin
      @(posedge pclk);
      tone_code <= 4'(c);
      tone_valid <= 1'b1;
      repeat (3) @(posedge pclk);
      apb(1'b0, ADDR_TONE_KEY, '0);
      chk("key while valid", {27'h0, 1'b1, 4'(c)}, rdat);
      tone_valid <= 1'b0;
      repeat (3) @(posedge pclk);
      apb(1'b0, ADDR_TONE_KEY, '0);
      chk("key after valid", {27'h0, 1'b0, 4'(c)}, rdat);
    end
    apb(1'b1, ADDR_PEND_MISC, 32'hff);
    @(posedge pclk);
    indirect_busy <= 1'b1;
    repeat (3) @(posedge pclk);
    apb(1'b0, ADDR_INDIRECT_STAT, '0);
    chk("indirect busy", 32'h1, rdat);
    apb(1'b0, ADDR_PEND_MISC, '0);
    chk("no done while busy", '0, rdat);
    indirect_busy <= 1'b0;
    repeat (3) @(posedge pclk);
    apb(1'b0, ADDR_INDIRECT_STAT, '0);
    chk("indirect idle", '0, rdat);
    apb(1'b0, ADDR_PEND_MISC, '0);
    chk("done flag", 32'h2, rdat);
    // ring trip landing on the edge of a clearing write keeps its flag
    fork
      apb(1'b1, ADDR_PEND_ALARM_LOOP, 32'hff);
      begin
        repeat (2) @(posedge pclk);
        ring_trip_evt <= 1'b1;
        @(posedge pclk);
        ring_trip_evt <= 1'b0;
      end
    join
    apb(1'b0, ADDR_PEND_ALARM_LOOP, '0);
    chk("set beats clear", 32'h1, rdat);
    apb(1'b1, ADDR_PEND_ALARM_LOOP, 32'h1);
    // an event while the clock enable is low is not taken
    @(posedge pclk);
    ce <= 1'b0;
    ring_trip_evt <= 1'b1;
    @(posedge pclk);
    ring_trip_evt <= 1'b0;
    @(posedge pclk);
    ce <= 1'b1;
    apb(1'b0, ADDR_PEND_ALARM_LOOP, '0);
    chk("frozen while ce low", '0, rdat);
    stop_test();
  end
endmodule : ift_irq_tone_tb_top

//--- rtl/ift_edge_det.sv
// per-bit rise and fall detector for level inputs, armed after first sample
`timescale 1ns/1ps
module ift_edge_det #(
  parameter int W = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [W-1:0] lvl,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  import ift_pkg::*;

  logic armed_r;

  // first enabled edge only learns the level, so a high level at reset is no event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_r <= 1'b0;
    end else if (ce) begin
      armed_r <= 1'b1;
    end
  end

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic prev_r;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          prev_r <= 1'b0;
        end else if (ce) begin
          prev_r <= lvl[i];
        end
      end
      assign rise[i] = armed_r & lvl[i] & ~prev_r;
      assign fall[i] = armed_r & ~lvl[i] & prev_r;
    end
  endgenerate

endmodule : ift_edge_det

//--- rtl/ift_irq_tone.sv
// interrupt pending flags, masks and tone key status behind an apb slave
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
module ift_irq_tone (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ift_pkg::ADDR_W-1:0] paddr,
  input wire logic [ift_pkg::DATA_W-1:0] pwdata,
  output logic [ift_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [ift_pkg::TIMER_N-1:0] timer_evt,
  input wire logic [ift_pkg::ALARM_N-1:0] power_alarm_evt,
  input wire logic hook_state,
  input wire logic ring_trip_evt,
  input wire logic calib_running,
  input wire logic indirect_busy,
  input wire logic tone_valid,
  input wire logic [3:0] tone_code,
  output logic irq
);
  import ift_pkg::*;

  // ==========================================================================
  // declarations
  logic [REG_W-1:0] pend_timers;
  logic [REG_W-1:0] pend_alarm_loop;
  logic [MISC_W-1:0] pend_misc;
  logic [REG_W-1:0] mask_timers_r;
  logic [REG_W-1:0] mask_alarm_loop_r;
  logic [MISC_W-1:0] mask_misc_r;
  logic key_present_r;
  ift_key_e key_code_r;
  logic indirect_busy_r;
  logic irq_r;
  logic [DATA_W-1:0] prdata_r;
  logic rd_valid_r;
  logic [DATA_W-1:0] rd_mux;
  logic addr_hit;
  logic access;
  logic wr_acc;
  logic [2:0] lvl_rise;
  logic [2:0] lvl_fall;
  logic loop_evt;
  logic calib_evt;
  logic indirect_evt;
  logic tone_evt;
  logic [REG_W-1:0] set_alarm_loop;
  logic [MISC_W-1:0] set_misc;
  logic [REG_W-1:0] clr_timers;
  logic [REG_W-1:0] clr_alarm_loop;
  logic [MISC_W-1:0] clr_misc;
  logic irq_nxt;

  // ==========================================================================
  // event detection on level inputs: hook, indirect busy, tone valid
  ift_edge_det #(
    .W(3)
  ) u_edge (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .lvl({tone_valid, indirect_busy, hook_state}),
    .rise(lvl_rise),
    .fall(lvl_fall)
  );

  assign loop_evt = lvl_rise[0] | lvl_fall[0];
  assign calib_evt = loop_evt & calib_running;
  assign indirect_evt = lvl_fall[1];
  assign tone_evt = lvl_rise[2];

  // ==========================================================================
  // apb slave
  assign access = psel & penable;
  // writes finish at once; reads wait for data captured from the flops
  assign pready = ce & (pwrite | rd_valid_r);
  assign wr_acc = access & pwrite & pready;
  assign pslverr = access & pready & ~addr_hit;
  assign prdata = prdata_r;

  always_comb begin
    rd_mux = '0;
    addr_hit = 1'b1;
    case (paddr)
      ADDR_PEND_TIMERS: rd_mux[REG_W-1:0] = pend_timers;
      ADDR_PEND_ALARM_LOOP: rd_mux[REG_W-1:0] = pend_alarm_loop;
      ADDR_PEND_MISC: rd_mux[MISC_W-1:0] = pend_misc;
      ADDR_MASK_TIMERS: rd_mux[REG_W-1:0] = mask_timers_r;
      ADDR_MASK_ALARM_LOOP: rd_mux[REG_W-1:0] = mask_alarm_loop_r;
      ADDR_MASK_MISC: rd_mux[MISC_W-1:0] = mask_misc_r;
      ADDR_TONE_KEY: begin
        rd_mux[KEY_PRESENT_BIT] = key_present_r;
        rd_mux[3:0] = key_code_r;
      end
      ADDR_INDIRECT_STAT: rd_mux[0] = indirect_busy_r;
      default: addr_hit = 1'b0;
    endcase
  end

  // read data is sampled while the transfer is open, then handed over
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
      rd_valid_r <= 1'b0;
    end else if (ce) begin
      if (psel && !pwrite && !(penable && pready)) begin
        prdata_r <= rd_mux;
        rd_valid_r <= 1'b1;
      end else begin
        rd_valid_r <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // pending flag banks
  assign set_alarm_loop = {power_alarm_evt, loop_evt, ring_trip_evt};
  assign set_misc = {calib_evt, indirect_evt, tone_evt};
  // only ones in the write data clear
  assign clr_timers = (wr_acc && paddr == ADDR_PEND_TIMERS) ? pwdata[REG_W-1:0] : '0;
  assign clr_alarm_loop = (wr_acc && paddr == ADDR_PEND_ALARM_LOOP) ?
                          pwdata[REG_W-1:0] : '0;
  assign clr_misc = (wr_acc && paddr == ADDR_PEND_MISC) ? pwdata[MISC_W-1:0] : '0;

  ift_w1c_bank #(
    .W(REG_W),
    .RST(RST_PEND)
  ) u_pend_timers (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .set(timer_evt),
    .clr(clr_timers),
    .pend(pend_timers)
  );

  ift_w1c_bank #(
    .W(REG_W),
    .RST(RST_PEND)
  ) u_pend_alarm_loop (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .set(set_alarm_loop),
    .clr(clr_alarm_loop),
    .pend(pend_alarm_loop)
  );

  ift_w1c_bank #(
    .W(MISC_W),
    .RST(RST_MISC)
  ) u_pend_misc (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .set(set_misc),
    .clr(clr_misc),
    .pend(pend_misc)
  );

  // ==========================================================================
  // mask registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_timers_r <= RST_MASK;
    end else if (ce && wr_acc && paddr == ADDR_MASK_TIMERS) begin
      mask_timers_r <= pwdata[REG_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_alarm_loop_r <= RST_MASK;
    end else if (ce && wr_acc && paddr == ADDR_MASK_ALARM_LOOP) begin
      mask_alarm_loop_r <= pwdata[REG_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_misc_r <= RST_MISC;
    end else if (ce && wr_acc && paddr == ADDR_MASK_MISC) begin
      mask_misc_r <= pwdata[MISC_W-1:0];
    end
  end

  // ==========================================================================
  // tone key status and indirect busy mirror
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_present_r <= 1'b0;
      key_code_r <= IFT_KEY_D;
    end else if (ce) begin
      key_present_r <= tone_valid;
      // last decoded key stays readable after the tone ends
      if (tone_valid) begin
        key_code_r <= ift_key_e'(tone_code);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      indirect_busy_r <= 1'b0;
    end else if (ce) begin
      indirect_busy_r <= indirect_busy;
    end
  end

  // ==========================================================================
  // interrupt output
  assign irq_nxt = |(pend_timers & mask_timers_r) |
                   |(pend_alarm_loop & mask_alarm_loop_r) |
                   |(pend_misc & mask_misc_r);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
    end else if (ce) begin
      irq_r <= irq_nxt;
    end
  end

  assign irq = irq_r;

  // ==========================================================================
  // assertions
  a_alarm_set: assert property (@(posedge pclk) disable iff (!presetn)
    ce && power_alarm_evt[0] |=> pend_alarm_loop[ALARM_LSB])
    else $error("power alarm 1 event did not set its flag");

  a_alarm_top: assert property (@(posedge pclk) disable iff (!presetn)
    ce && power_alarm_evt[ALARM_N-1] |=> pend_alarm_loop[REG_W-1])
    else $error("power alarm 6 event did not set bit 7");

  a_w1c_clear: assert property (@(posedge pclk) disable iff (!presetn)
    ce && wr_acc && paddr == ADDR_PEND_ALARM_LOOP && pwdata[LOOP_BIT] && !loop_evt
    |=> !pend_alarm_loop[LOOP_BIT])
    else $error("writing one did not clear the loop flag");

  a_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
    ce && wr_acc && paddr == ADDR_PEND_ALARM_LOOP && pwdata[RING_BIT] && ring_trip_evt
    |=> pend_alarm_loop[RING_BIT])
    else $error("ring trip lost against a clear");

  a_zero_keeps: assert property (@(posedge pclk) disable iff (!presetn)
    ce && wr_acc && paddr == ADDR_PEND_TIMERS && !pwdata[REG_W-1] && pend_timers[REG_W-1]
    |=> pend_timers[REG_W-1])
    else $error("writing zero changed a timer flag");

  a_loop_edge: assert property (@(posedge pclk) disable iff (!presetn)
    ce && hook_state && !$past(hook_state) && $past(ce) && $past(ce, 2)
    |=> pend_alarm_loop[LOOP_BIT])
    else $error("hook change did not set the loop flag");

  a_ring_trip: assert property (@(posedge pclk) disable iff (!presetn)
    ce && ring_trip_evt && !wr_acc && !loop_evt && power_alarm_evt == '0
    |=> pend_alarm_loop == ($past(pend_alarm_loop) | {ALARM_N'(0), 2'b01}))
    else $error("ring trip did not set bit 0 alone");

  a_calib_err: assert property (@(posedge pclk) disable iff (!presetn)
    ce && loop_evt && calib_running |=> pend_misc[CALIB_BIT] && pend_alarm_loop[LOOP_BIT])
    else $error("hook change during calibration not flagged");

  a_no_calib: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !calib_running && !pend_misc[CALIB_BIT] && !wr_acc |=> !pend_misc[CALIB_BIT])
    else $error("calibration error set while no calibration ran");

  a_indirect: assert property (@(posedge pclk) disable iff (!presetn)
    ce && indirect_evt |=> pend_misc[INDIRECT_BIT] && !indirect_busy_r)
    else $error("end of indirect access did not set its flag");

  a_tone_set: assert property (@(posedge pclk) disable iff (!presetn)
    ce && tone_evt |=> pend_misc[TONE_BIT] ##0 key_present_r)
    else $error("tone detection did not set its flag");

  a_rsv_zero: assert property (@(posedge pclk) disable iff (!presetn)
    rd_valid_r && (paddr == ADDR_PEND_MISC || paddr == ADDR_MASK_MISC)
    |-> prdata[DATA_W-1:MISC_W] == '0)
    else $error("reserved misc bits read nonzero");

  a_key_rsv: assert property (@(posedge pclk) disable iff (!presetn)
    rd_valid_r && paddr == ADDR_TONE_KEY |-> prdata[DATA_W-1:KEY_PRESENT_BIT+1] == '0)
    else $error("reserved key status bits read nonzero");

  a_mask_write: assert property (@(posedge pclk) disable iff (!presetn)
    ce && wr_acc && paddr == ADDR_MASK_TIMERS |=> mask_timers_r == $past(pwdata[REG_W-1:0]))
    else $error("timer mask write not stored");

  a_irq_enabled: assert property (@(posedge pclk) disable iff (!presetn)
    ce && (pend_alarm_loop & mask_alarm_loop_r) != '0 |=> irq)
    else $error("enabled pending flag did not raise irq");

  a_irq_masked: assert property (@(posedge pclk) disable iff (!presetn)
    ce && mask_timers_r == '0 && mask_alarm_loop_r == '0 && mask_misc_r == '0 |=> !irq)
    else $error("irq raised with all masks clear");

  a_key_valid: assert property (@(posedge pclk) disable iff (!presetn)
    ce |=> key_present_r == $past(tone_valid))
    else $error("key present does not follow the detector");

  a_key_code: assert property (@(posedge pclk) disable iff (!presetn)
    ce && tone_valid |=> key_code_r == $past(tone_code))
    else $error("key code not captured");

  a_alarm_mask: assert property (@(posedge pclk) disable iff (!presetn)
    ce && wr_acc && paddr == ADDR_MASK_ALARM_LOOP |=> mask_alarm_loop_r == $past(pwdata[REG_W-1:0]))
    else $error("alarm and loop mask write not stored");

  a_misc_mask: assert property (@(posedge pclk) disable iff (!presetn)
    ce && wr_acc && paddr == ADDR_MASK_MISC |=> mask_misc_r == $past(pwdata[MISC_W-1:0]))
    else $error("misc mask write not stored");

  a_busy_mirror: assert property (@(posedge pclk) disable iff (!presetn)
    ce |=> indirect_busy_r == $past(indirect_busy))
    else $error("indirect busy status does not follow its input");

  a_freeze_flags: assert property (@(posedge pclk) disable iff (!presetn)
    !ce |=> pend_alarm_loop == $past(pend_alarm_loop) && irq == $past(irq))
    else $error("state changed while the clock enable was low");

endmodule : ift_irq_tone

//--- rtl/ift_pkg.sv
// shared constants for the interrupt flag and tone decode block
package ift_pkg;

  // ==========================================================================
  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam int MISC_W = 3;
  localparam int ALARM_N = 6;
  localparam int TIMER_N = 8;

  // ==========================================================================
  // register indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_PEND_TIMERS = 8'h12;
  localparam logic [ADDR_W-1:0] IDX_PEND_ALARM_LOOP = 8'h13;
  localparam logic [ADDR_W-1:0] IDX_PEND_MISC = 8'h14;
  localparam logic [ADDR_W-1:0] IDX_MASK_TIMERS = 8'h15;
  localparam logic [ADDR_W-1:0] IDX_MASK_ALARM_LOOP = 8'h16;
  localparam logic [ADDR_W-1:0] IDX_MASK_MISC = 8'h17;
  localparam logic [ADDR_W-1:0] IDX_TONE_KEY = 8'h18;
  localparam logic [ADDR_W-1:0] IDX_INDIRECT_STAT = 8'h1f;

  localparam logic [ADDR_W-1:0] ADDR_PEND_TIMERS = {IDX_PEND_TIMERS[ADDR_W-3:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_PEND_ALARM_LOOP = {IDX_PEND_ALARM_LOOP[ADDR_W-3:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_PEND_MISC = {IDX_PEND_MISC[ADDR_W-3:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_MASK_TIMERS = {IDX_MASK_TIMERS[ADDR_W-3:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_MASK_ALARM_LOOP = {IDX_MASK_ALARM_LOOP[ADDR_W-3:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_MASK_MISC = {IDX_MASK_MISC[ADDR_W-3:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_TONE_KEY = {IDX_TONE_KEY[ADDR_W-3:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_INDIRECT_STAT = {IDX_INDIRECT_STAT[ADDR_W-3:0], 2'b00};

  // ==========================================================================
  // field positions
  localparam int ALARM_LSB = 2;
  localparam int LOOP_BIT = 1;
  localparam int RING_BIT = 0;
  localparam int CALIB_BIT = 2;
  localparam int INDIRECT_BIT = 1;
  localparam int TONE_BIT = 0;
  localparam int KEY_PRESENT_BIT = 4;

  // ==========================================================================
  // values after reset
  localparam logic [REG_W-1:0] RST_PEND = 8'h00;
  localparam logic [REG_W-1:0] RST_MASK = 8'h00;
  localparam logic [MISC_W-1:0] RST_MISC = 3'h0;

  // ==========================================================================
  // key codes reported by the tone detector
  typedef enum logic [3:0] {
    IFT_KEY_D = 4'h0, IFT_KEY_1 = 4'h1, IFT_KEY_2 = 4'h2, IFT_KEY_3 = 4'h3,
    IFT_KEY_4 = 4'h4, IFT_KEY_5 = 4'h5, IFT_KEY_6 = 4'h6, IFT_KEY_7 = 4'h7,
    IFT_KEY_8 = 4'h8, IFT_KEY_9 = 4'h9, IFT_KEY_0 = 4'ha, IFT_KEY_STAR = 4'hb,
    IFT_KEY_HASH = 4'hc, IFT_KEY_A = 4'hd, IFT_KEY_B = 4'he, IFT_KEY_C = 4'hf
  } ift_key_e;

endpackage : ift_pkg

//--- rtl/ift_w1c_bank.sv
// bank of sticky pending flags, set by events and cleared by writing one
`timescale 1ns/1ps
module ift_w1c_bank #(
  parameter int W = 8,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  output logic [W-1:0] pend
);
  import ift_pkg::*;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_flag
      // set beats a clear landing in the same cycle; a zero write leaves the flag
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pend[i] <= RST[i];
        end else if (ce) begin
          if (set[i]) begin
            pend[i] <= 1'b1;
          end else if (clr[i]) begin
            pend[i] <= 1'b0;
          end
        end
      end
    end
  endgenerate

endmodule : ift_w1c_bank
